//--- bmc_consts.vh
`ifndef BMC_CONSTS_VH
`define BMC_CONSTS_VH

// register byte offsets
`define BMC_OFF_SWAP_NEW      8'h0C
`define BMC_OFF_SWAP_EXP      8'h10
`define BMC_OFF_SWAP_CTRL     8'h14
`define BMC_OFF_ROM_HDR       8'h18
`define BMC_OFF_BUS_SIG       8'h1C
`define BMC_OFF_IRQ_STATUS    8'h40
`define BMC_OFF_IRQ_MASK      8'h44
`define BMC_OFF_RES_BASE      8'h50

// swap control fields
`define BMC_DONE_BIT          31
`define BMC_SEL_HI            1
`define BMC_SEL_LO            0

// resource select codes
`define BMC_SEL_BUS_MGR       2'h0
`define BMC_SEL_BANDWIDTH     2'h1
`define BMC_SEL_CHAN_HI       2'h2
`define BMC_SEL_CHAN_LO       2'h3

// link-side selects: 0..3 are the resources
`define BMC_LSEL_ROM_HDR      3'h4
`define BMC_LSEL_BUS_SIG      3'h5

// reset values
`define BMC_RST_SWAP          32'h00000000
`define BMC_RST_ROM_HDR_HI    16'h0000
`define BMC_RST_ROM_HDR_LO    16'h0000
`define BMC_BUS_SIG_VALUE     32'h31333934
`define BMC_RST_RESOURCE      32'h00000000

// interrupt bits
`define BMC_IRQ_SWAP_DONE     0
`define BMC_IRQ_ROM_LOADED    1
`define BMC_IRQ_BITS          2

// axi responses
`define BMC_RESP_OKAY         2'h0
`define BMC_RESP_DECERR       2'h3

`endif

//--- bmc_swap_regs.v
// Overview of operation
// [RULE_01] swap value register holds word written on success
// [RULE_02] expected register compared with selected resource
// [RULE_03] completion flag bit 31 set when swap finishes
// [RULE_04] any control write clears completion flag
// [RULE_05] two-bit select picks one of four resources
// [RULE_06] middle bits read zero; select resets zero
// [RULE_07] rom header is first configuration rom quadlet
// [RULE_08] host programs header fields before link enable
// [RULE_09] serial rom loads the rom check value field
// [RULE_10] header upper half resets to zero
// [RULE_11] bus signature register is constant, read-only
// [RULE_12] bus signature is first bus info quadlet
// [RULE_13] control write starts one atomic compare-swap
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "bmc_consts.vh"

module bmc_swap_regs #(
    parameter [31:0] RES_RESET = `BMC_RST_RESOURCE
) (
    input  wire        clock,
    input  wire        rst,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // serial-bus side access to resources and rom quadlets
    input  wire        linkReq,
    input  wire [2:0]  linkSel,
    input  wire        linkLock,
    input  wire [31:0] linkArg,
    input  wire [31:0] linkData,
    output reg         linkAck,
    output reg  [31:0] linkOld,
    // serial rom check value load
    input  wire        romCrcLoad,
    input  wire [15:0] romCrcValue,
    output wire        irq
);

    reg  [31:0] swapNewValue;
    reg  [31:0] swapExpValue;
    reg         swapComplete;
    reg  [1:0]  resourceSelect;
    reg  [31:0] romHeader;
    reg  [`BMC_IRQ_BITS-1:0] irqStatus;
    reg  [`BMC_IRQ_BITS-1:0] irqMask;
    reg  [31:0] resource [0:3];
    reg         swapPending;

    reg         awHeld;
    reg  [7:0]  awAddr;
    reg         wHeld;
    reg  [31:0] wData;
    reg  [3:0]  wStrb;

    wire        doWrite;
    wire        doRead;
    wire        ctrlWrite;
    wire        swapRun;
    wire        linkRun;
    wire [31:0] selValue;
    wire        swapHit;
    reg  [31:0] rdValue;
    reg         rdMapped;
    reg         wrMapped;
    wire [7:0]  wrWord;
    wire [7:0]  rdWord;
    wire        hitNew;
    wire        hitExp;
    wire        hitCtrl;
    wire        hitRom;
    wire        hitStatus;
    wire        hitMask;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer      b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // write channel: address and data taken in either order, held until response
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddr <= 8'h00;
            wHeld  <= 1'b0;
            wData  <= 32'h00000000;
            wStrb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // write decode on the held word address; the two low address bits are ignored
    assign wrWord    = {awAddr[7:2], 2'b00};
    assign hitNew    = (wrWord == `BMC_OFF_SWAP_NEW);
    assign hitExp    = (wrWord == `BMC_OFF_SWAP_EXP);
    assign hitCtrl   = (wrWord == `BMC_OFF_SWAP_CTRL);
    assign hitRom    = (wrWord == `BMC_OFF_ROM_HDR);
    assign hitStatus = (wrWord == `BMC_OFF_IRQ_STATUS);
    assign hitMask   = (wrWord == `BMC_OFF_IRQ_MASK);

    always @* begin
        case (wrWord)
            `BMC_OFF_SWAP_NEW,
            `BMC_OFF_SWAP_EXP,
            `BMC_OFF_SWAP_CTRL,
            `BMC_OFF_ROM_HDR,
            `BMC_OFF_BUS_SIG,
            `BMC_OFF_IRQ_STATUS,
            `BMC_OFF_IRQ_MASK: wrMapped = 1'b1;
            default:           wrMapped = 1'b0;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `BMC_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? `BMC_RESP_OKAY : `BMC_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign ctrlWrite = doWrite && hitCtrl;

    // host swap runs the cycle after the control write; the link waits that
    // cycle so a resource is never read and written by both in one go
    assign swapRun  = swapPending;
    assign linkRun  = linkReq && !swapPending && !linkAck;
    assign selValue = resource[resourceSelect];
    assign swapHit  = (selValue == swapExpValue);                          // [RULE_02]

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            swapPending <= 1'b0;
        end else begin
            swapPending <= ctrlWrite;                                      // [RULE_13]
        end
    end

    // operands are host-loaded; a swap reads them and never alters them
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            swapNewValue <= `BMC_RST_SWAP;
        end else if (doWrite && hitNew) begin
            swapNewValue <= merge(swapNewValue, wData, wStrb);
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            swapExpValue <= `BMC_RST_SWAP;
        end else if (doWrite && hitExp) begin
            swapExpValue <= merge(swapExpValue, wData, wStrb);
        end
    end

    // the select sits in the low byte lane; a write without that lane leaves it
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            resourceSelect <= `BMC_SEL_BUS_MGR;                            // [RULE_06]
        end else if (ctrlWrite && wStrb[0]) begin
            resourceSelect <= wData[`BMC_SEL_HI:`BMC_SEL_LO];              // [RULE_05]
        end
    end

    // the rom load lands after a same-cycle host write to the field
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            romHeader <= {`BMC_RST_ROM_HDR_HI, `BMC_RST_ROM_HDR_LO};       // [RULE_10]
        end else begin
            if (doWrite && hitRom) begin
                romHeader <= merge(romHeader, wData, wStrb);
            end
            if (romCrcLoad) begin
                romHeader[15:0] <= romCrcValue;                            // [RULE_09]
            end
        end
    end

    // mask bits live in the low byte lane as well
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            irqMask <= {`BMC_IRQ_BITS{1'b0}};
        end else if (doWrite && hitMask && wStrb[0]) begin
            irqMask <= wData[`BMC_IRQ_BITS-1:0];
        end
    end

    // completion flag: set by the finishing swap wins over the clearing write
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            swapComplete <= 1'b0;
        end else if (swapRun) begin
            swapComplete <= 1'b1;                                          // [RULE_03]
        end else if (ctrlWrite) begin
            swapComplete <= 1'b0;                                          // [RULE_04]
        end
    end

    // resources: one writer per cycle keeps each compare-swap atomic
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : resReg
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    resource[gi] <= RES_RESET;
                end else if (swapRun && swapHit && resourceSelect == gi) begin
                    resource[gi] <= swapNewValue;                          // [RULE_01]
                end else if (linkRun && linkLock && linkSel == gi
                             && resource[gi] == linkArg) begin
                    resource[gi] <= linkData;                              // [RULE_13]
                end
            end
        end
    endgenerate

    // link side answers one cycle after its request is taken
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            linkAck <= 1'b0;
        end else begin
            linkAck <= linkRun;
        end
    end

    // the old value stands until the next acknowledge replaces it
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            linkOld <= 32'h00000000;
        end else if (linkRun) begin
            case (linkSel)
                `BMC_LSEL_ROM_HDR: linkOld <= romHeader;                   // [RULE_07]
                `BMC_LSEL_BUS_SIG: linkOld <= `BMC_BUS_SIG_VALUE;          // [RULE_12]
                3'h0, 3'h1, 3'h2, 3'h3: linkOld <= resource[linkSel[1:0]];
                default:           linkOld <= 32'h00000000;
            endcase
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStatus <= {`BMC_IRQ_BITS{1'b0}};
        end else begin
            if (doWrite && hitStatus && wStrb[0]) begin
                irqStatus <= irqStatus & ~wData[`BMC_IRQ_BITS-1:0];
            end
            if (swapRun) begin
                irqStatus[`BMC_IRQ_SWAP_DONE] <= 1'b1;
            end
            if (romCrcLoad) begin
                irqStatus[`BMC_IRQ_ROM_LOADED] <= 1'b1;
            end
        end
    end

    assign irq = |(irqStatus & irqMask);

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign doRead        = s_axi_arvalid && s_axi_arready;
    assign rdWord        = {s_axi_araddr[7:2], 2'b00};

    always @* begin
        rdValue  = 32'h00000000;
        rdMapped = 1'b1;
        case (rdWord)
            `BMC_OFF_SWAP_NEW:   rdValue = swapNewValue;
            `BMC_OFF_SWAP_EXP:   rdValue = swapExpValue;
            `BMC_OFF_SWAP_CTRL:
                rdValue = {swapComplete, 29'h00000000, resourceSelect};    // [RULE_06]
            `BMC_OFF_ROM_HDR:    rdValue = romHeader;
            `BMC_OFF_BUS_SIG:    rdValue = `BMC_BUS_SIG_VALUE;             // [RULE_11]
            `BMC_OFF_IRQ_STATUS: rdValue = {30'h00000000, irqStatus};
            `BMC_OFF_IRQ_MASK:   rdValue = {30'h00000000, irqMask};
            // resources are read-only to the host; only a swap changes them
            `BMC_OFF_RES_BASE:   rdValue = resource[0];
            `BMC_OFF_RES_BASE + 8'h04: rdValue = resource[1];
            `BMC_OFF_RES_BASE + 8'h08: rdValue = resource[2];
            `BMC_OFF_RES_BASE + 8'h0C: rdValue = resource[3];
            default:             rdMapped = 1'b0;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `BMC_RESP_OKAY;
        end else if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdValue;
            s_axi_rresp  <= rdMapped ? `BMC_RESP_OKAY : `BMC_RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

//--- bmc_swap_checker.sv
`timescale 1ns/1ps
`include "bmc_consts.vh"
module bmc_swap_checker (
    input wire        clock,
    input wire        rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        linkReq,
    input wire [2:0]  linkSel,
    input wire        linkAck,
    input wire [31:0] linkOld
);
    logic [7:0] rdAddr;
    // rdata carries no address, so remember which word the pending read asked for
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdAddr <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rdAddr <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence linkTaken;
        linkReq && !linkAck;
    endsequence
    a_write_answer: assert property (wrTaken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_ctrl_zero: assert property (s_axi_rvalid && rdAddr == `BMC_OFF_SWAP_CTRL
        |-> s_axi_rdata[30:2] == 29'h0)
        else $error("control middle bits not zero");
    a_sig_const: assert property (s_axi_rvalid && rdAddr == `BMC_OFF_BUS_SIG
        |-> s_axi_rdata == `BMC_BUS_SIG_VALUE)
        else $error("bus signature wrong");
    a_link_answer: assert property (linkTaken |-> ##[1:2] linkAck)
        else $error("link acknowledge late");
    a_ack_pulse: assert property (linkAck |=> !linkAck)
        else $error("link acknowledge longer than one cycle");
    a_link_sig: assert property (linkAck && $past(linkSel) == `BMC_LSEL_BUS_SIG
        |-> linkOld == `BMC_BUS_SIG_VALUE)
        else $error("link signature wrong");
endmodule
bind bmc_swap_regs bmc_swap_checker chk (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .linkReq, .linkSel, .linkAck, .linkOld);

//--- tb_top.sv
`timescale 1ns/1ps
`include "bmc_consts.vh"
module tb_top;
    typedef struct {string name; logic [33:0] value;} bmc_note_t;
    logic        clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, linkReq, linkLock, romCrcLoad;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, linkArg, linkData, res [4], hdr, v;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  linkSel;
    logic [15:0] romCrcValue;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         linkAck, irq;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, linkOld;
    bmc_note_t   rdQ[$], wrQ[$], lkQ[$], n;
    integer      seed = 32'hE065;
    int          nMismatch = 0, samplesChecked = 0, cycles = 0;

    bmc_swap_regs uut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .linkReq, .linkSel, .linkLock, .linkArg, .linkData,
        .linkAck, .linkOld, .romCrcLoad, .romCrcValue, .irq);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic compare(string name, logic [33:0] exp, logic [33:0] seen);
        samplesChecked++;
        if (exp !== seen) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // results are noted by the drivers and matched here as they appear
    always @(posedge clock) begin
        cycles++;
        if (s_axi_rvalid && s_axi_rready) begin
            n = rdQ.pop_front();
            compare(n.name, n.value, {s_axi_rresp, s_axi_rdata});
        end
        if (s_axi_bvalid && s_axi_bready) begin
            n = wrQ.pop_front();
            compare(n.name, n.value, {s_axi_bresp, 32'h0});
        end
        if (linkAck) begin
            n = lkQ.pop_front();
            compare(n.name, n.value, {2'h0, linkOld});
        end
        if (cycles == 20000) begin
            nMismatch++;
            tallyAndFinish();
        end
    end

    task automatic axiWrite(logic [7:0] a, logic [31:0] d, logic [1:0] resp);
        bit ad = 0;
        bit dd = 0;
        wrQ.push_back('{"bresp", {resp, 32'h0}});
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // each channel is released at its own handshake, whichever comes first
        while (!(ad && dd)) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                dd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(logic [7:0] a, logic [33:0] exp, string name);
        rdQ.push_back('{name, exp});
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic linkOp(logic [2:0] sel, logic lock, logic [31:0] arg, dat, exp);
        lkQ.push_back('{"linkOld", {2'h0, exp}});
        @(posedge clock);
        linkSel <= sel;
        linkLock <= lock;
        linkArg <= arg;
        linkData <= dat;
        linkReq <= 1'b1;
        do @(posedge clock); while (!linkAck);
        linkReq <= 1'b0;
    endtask

    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, linkReq, linkSel, linkLock} = '0;
        {linkArg, linkData, romCrcLoad, romCrcValue} = '0;
        s_axi_wstrb = 4'hF;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            res[i] = 32'h0;
            axiRead(8'(8'h0C + 4 * i), 34'h0, "resetValue");
        end
        axiRead(`BMC_OFF_BUS_SIG, {2'h0, `BMC_BUS_SIG_VALUE}, "busSig");
        axiWrite(`BMC_OFF_IRQ_MASK, 32'h3, `BMC_RESP_OKAY);
        // select 3 is given a wrong expected value, so its swap must leave it alone
        for (int s = 0; s < 4; s++) begin
            v = $random(seed);
            axiWrite(`BMC_OFF_SWAP_NEW, v, `BMC_RESP_OKAY);
            axiWrite(`BMC_OFF_SWAP_EXP, res[s] ^ (s == 3), `BMC_RESP_OKAY);
            axiWrite(`BMC_OFF_SWAP_CTRL, ($random(seed) & 32'hFFFFFFFC) | s, 2'h0);
            if (s != 3) res[s] = v;
            axiRead(`BMC_OFF_SWAP_CTRL, {3'h1, 29'h0, s[1:0]}, "control");
            axiRead(8'(`BMC_OFF_RES_BASE + 4 * s), {2'h0, res[s]}, "resource");
        end
        // a control write without the low byte lane must keep select 3
        s_axi_wstrb <= 4'hE;
        axiWrite(`BMC_OFF_SWAP_CTRL, 32'h0, `BMC_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axiRead(`BMC_OFF_SWAP_CTRL, {3'h1, 29'h0, 2'h3}, "ctrlStrobe");
        compare("irqSwap", 34'h1, {33'h0, irq});
        axiWrite(`BMC_OFF_IRQ_STATUS, 32'h1, `BMC_RESP_OKAY);
        compare("irqClear", 34'h0, {33'h0, irq});
        for (int s = 0; s < 4; s++) begin
            v = $random(seed);
            linkOp(3'(s), 1'b1, res[s], v, res[s]);
            res[s] = v;
            axiRead(8'(`BMC_OFF_RES_BASE + 4 * s), {2'h0, res[s]}, "linkSwap");
        end
        linkOp(3'h0, 1'b1, ~res[0], v, res[0]);
        axiRead(`BMC_OFF_RES_BASE, {2'h0, res[0]}, "linkNoSwap");
        hdr = $random(seed);
        axiWrite(`BMC_OFF_ROM_HDR, hdr, `BMC_RESP_OKAY);
        v = $random(seed);
        @(posedge clock);
        romCrcValue <= v[15:0];
        romCrcLoad <= 1'b1;
        @(posedge clock);
        romCrcLoad <= 1'b0;
        hdr[15:0] = v[15:0];
        axiRead(`BMC_OFF_ROM_HDR, {2'h0, hdr}, "romHeader");
        compare("irqRom", 34'h1, {33'h0, irq});
        linkOp(`BMC_LSEL_ROM_HDR, 1'b0, 32'h0, 32'h0, hdr);
        linkOp(`BMC_LSEL_BUS_SIG, 1'b0, 32'h0, 32'h0, `BMC_BUS_SIG_VALUE);
        linkOp(3'h6, 1'b1, 32'h0, 32'h0, 32'h0);
        axiRead(8'h30, {`BMC_RESP_DECERR, 32'h0}, "unmapped");
        axiWrite(8'h30, v, `BMC_RESP_DECERR);
        tallyAndFinish();
    end
endmodule
